// File: hdl/osdw_pkg.sv
package osdw_pkg;

  // display ram geometry
  localparam int RAM_AW   = 9;
  localparam int RAM_DW   = 16;
  localparam int NUM_WIN  = 4;
  localparam int GLYPH_W  = 12;

  // frame control row and register columns
  localparam logic [3:0] CTRL_ROW      = 4'hF;
  localparam logic [4:0] WIN_REG_BASE  = 5'h05;
  localparam logic [4:0] PRIO_REG      = 5'h0D;

  // odd register of a window pair
  localparam int COLOR_LSB = 12;
  localparam int FROW_LSB  = 8;
  localparam int HSH_LSB   = 6;
  localparam int VSH_LSB   = 4;
  localparam int LROW_LSB  = 0;

  // even register of a window pair
  localparam int ON_BIT    = 15;
  localparam int FCOL_LSB  = 8;
  localparam int SHON_BIT  = 7;
  localparam int LCOL_LSB  = 0;

  // rank selectors, highest rank first
  localparam int RANK_STRIDE = 4;

  // character attribute word
  localparam int CODE_LSB = 0;
  localparam int RR_BIT   = 11;
  localparam int RG_BIT   = 12;
  localparam int RB_BIT   = 13;

  // font rom addressing
  localparam int         FONT_GLYPHS     = 464;
  localparam int         FONT_SINGLE     = 448;
  localparam logic [8:0] FONT_BLANK      = 9'h000;
  localparam logic [4:0] FONT_MULTI_TAG  = 5'h1C;
  localparam logic [8:0] FONT_G_OFS      = 9'h010;
  localparam logic [8:0] FONT_B_OFS      = 9'h020;

  // timing
  localparam int RAM_CLK_DOTS   = 12;
  localparam int ERASE_CELLS    = 480;
  localparam int ERASE_TIME_MS  = 30;
  localparam int ERASE_MIN_CYC  = (ERASE_CELLS - 1) * RAM_CLK_DOTS + 1;
  localparam int ERASE_MAX_CYC  = ERASE_CELLS * RAM_CLK_DOTS;

  typedef enum logic [0:0] {
    MODE_SHOW  = 1'b0,
    MODE_ERASE = 1'b1
  } osdw_mode_e;

  typedef struct packed {
    osdw_mode_e       mode;
    logic [3:0]       div;
    logic [8:0]       erase_addr;
    logic [3:0][15:0] win_rows;
    logic [3:0][15:0] win_cols;
    logic [15:0]      prio;
    logic             host_ack;
    logic             disp_rd;
    logic [3:0]       fetch_row;
    logic [15:0]      attr;
    logic [8:0]       font_addr_r;
    logic [8:0]       font_addr_g;
    logic [8:0]       font_addr_b;
    logic [11:0]      glyph_bits;
    logic [3:0]       raster_color;
    logic             window_hit;
    logic             shadow_hit;
    logic [1:0]       window_index;
  } osdw_state_s;

  localparam osdw_state_s STATE_RST = '0;

endpackage

// File: hdl/osdw_ram.sv
`timescale 1ns/1ps
module osdw_ram #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  // clock
  input  wire logic          core_clk,
  // access port
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  if (AW < 1 || AW > 16 || DW < 1) begin : g_bad_geom
    $error("osdw_ram geometry out of range");
  end

  logic [DW-1:0] mem [2**AW];

  // read data comes out of a register, held unchanged on a write
  always_ff @(posedge core_clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
    if (en && !we) begin
      rdata <= mem[addr];
    end
  end

endmodule

// File: hdl/osdw_top.sv
// Operation
// - window raster colour replaces character raster colour
// - first row from odd register bits 11:8
// - last row from odd register bits 3:0
// - shadow width is twice field, in dots
// - shadow height is twice field, in lines
// - window shown only while enable bit set
// - first column from even register bits 12:8
// - last column from even register low bits
// - shadow drawn only when shadow enable set
// - window n uses columns 5+2n and 6+2n
// - four rank selectors, bits 1:0 highest
// - higher ranked window covers lower ones
// - 512x16 ram, 16 rows of 32 columns
// - erase clears rows 0-14, keeps row 15
// - erase clears one cell per twelve dots
// - 464 glyphs: 448 single, 16 multi-colour
// - font address zero is a blank glyph
// - multi-colour glyph ORs red, green, blue planes
// - font address: row msb plus character code
// - bounds measured from top-left display cell
`timescale 1ns/1ps
module osdw_top #(
  parameter int RAM_CLK_DIV = osdw_pkg::RAM_CLK_DOTS
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // host register and ram port
  input  wire logic        host_req,
  input  wire logic        host_we,
  input  wire logic [3:0]  host_row,
  input  wire logic [4:0]  host_col,
  input  wire logic [15:0] host_wdata,
  output logic             host_ack,
  output logic      [15:0] host_rdata,
  // erase control
  input  wire logic        erase_req,
  output logic             erase_busy,
  // scan position inside the display area
  input  wire logic [3:0]  scan_row,
  input  wire logic [4:0]  scan_col,
  input  wire logic [3:0]  scan_dot,
  input  wire logic [5:0]  scan_line,
  input  wire logic        backdrop_intensity,
  // font rom
  output logic      [8:0]  font_addr_r,
  output logic      [8:0]  font_addr_g,
  output logic      [8:0]  font_addr_b,
  input  wire logic [11:0] font_bits_r,
  input  wire logic [11:0] font_bits_g,
  input  wire logic [11:0] font_bits_b,
  output logic      [11:0] glyph_bits,
  // window composite
  output logic      [3:0]  raster_color,
  output logic             window_hit,
  output logic             shadow_hit,
  output logic      [1:0]  window_index
);
  import osdw_pkg::*;

  if (RAM_CLK_DIV < 2 || RAM_CLK_DIV > 16) begin : g_bad_div
    $error("RAM_CLK_DIV must lie in 2..16");
  end

  localparam logic [3:0] DIV_LAST   = 4'(RAM_CLK_DIV - 1);
  localparam logic [8:0] ERASE_LAST = 9'(ERASE_CELLS - 1);

  osdw_state_s st;
  osdw_state_s next_st;

  logic                  tick;
  logic                  ram_en;
  logic                  ram_we;
  logic [RAM_AW-1:0]     ram_addr;
  logic [RAM_DW-1:0]     ram_wdata;
  logic [RAM_DW-1:0]     ram_q;
  logic [NUM_WIN-1:0]    hit_vec;
  logic [NUM_WIN-1:0]    shade_vec;
  logic [8:0]            code_addr;

  // cell inside a window rectangle, both bounds included
  function automatic logic in_area(input logic [3:0]  row,
                                   input logic [4:0]  col,
                                   input logic [15:0] rr,
                                   input logic [15:0] cr);
    in_area = cr[ON_BIT]
              && row >= rr[FROW_LSB +: 4]
              && row <= rr[LROW_LSB +: 4]
              && col >= cr[FCOL_LSB +: 5]
              && col <= cr[LCOL_LSB +: 5];
  endfunction

  // drop shadow to the right of and below the rectangle
  function automatic logic in_shadow(input logic [3:0]  row,
                                     input logic [4:0]  col,
                                     input logic [3:0]  dot,
                                     input logic [5:0]  line,
                                     input logic [15:0] rr,
                                     input logic [15:0] cr);
    logic [3:0] hs;
    logic [5:0] vs;
    logic       below_band;
    logic       right_side;
    logic       below_side;
    hs = {1'b0, rr[HSH_LSB +: 2], 1'b0};
    vs = {3'b000, rr[VSH_LSB +: 2], 1'b0};
    below_band = (row == rr[LROW_LSB +: 4] + 4'h1) && (line < vs);
    right_side = (col == cr[LCOL_LSB +: 5] + 5'h01) && (dot < hs)
                 && row >= rr[FROW_LSB +: 4]
                 && (row <= rr[LROW_LSB +: 4] || below_band);
    below_side = below_band && col >= cr[FCOL_LSB +: 5] && col <= cr[LCOL_LSB +: 5];
    in_shadow = cr[ON_BIT] && cr[SHON_BIT] && (right_side || below_side);
  endfunction

  osdw_ram #(
    .AW (RAM_AW),
    .DW (RAM_DW)
  ) u_ram (
    .core_clk (core_clk),
    .en       (ram_en),
    .we       (ram_we),
    .addr     (ram_addr),
    .wdata    (ram_wdata),
    .rdata    (ram_q)
  );

  assign tick = (st.div == DIV_LAST);
  assign code_addr = {st.fetch_row[3], ram_q[CODE_LSB +: 8]};

  always_comb begin
    next_st   = st;
    ram_en    = 1'b0;
    ram_we    = 1'b0;
    ram_addr  = '0;
    ram_wdata = '0;
    next_st.host_ack = 1'b0;
    next_st.disp_rd  = 1'b0;
    next_st.div = tick ? 4'h0 : st.div + 4'h1;

    unique case (st.mode)
      MODE_ERASE: begin
        // host accesses wait for the sweep to end
        if (tick) begin
          ram_en   = 1'b1;
          ram_we   = 1'b1;
          ram_addr = st.erase_addr;
          next_st.erase_addr = st.erase_addr + 9'h001;
          if (st.erase_addr == ERASE_LAST) begin
            next_st.mode = MODE_SHOW;
          end
        end
      end
      MODE_SHOW: begin
        if (tick) begin
          ram_en   = 1'b1;
          ram_addr = {scan_row, scan_col};
          next_st.disp_rd   = 1'b1;
          next_st.fetch_row = scan_row;
        end else if (host_req && !st.host_ack) begin
          ram_en    = 1'b1;
          ram_we    = host_we;
          ram_addr  = {host_row, host_col};
          ram_wdata = host_wdata;
          next_st.host_ack = 1'b1;
          if (host_we && host_row == CTRL_ROW) begin
            for (int w = 0; w < NUM_WIN; w++) begin
              if (host_col == WIN_REG_BASE + 5'(2 * w)) begin
                next_st.win_rows[w] = host_wdata;
              end
              if (host_col == WIN_REG_BASE + 5'(2 * w + 1)) begin
                next_st.win_cols[w] = host_wdata;
              end
            end
            if (host_col == PRIO_REG) begin
              next_st.prio = host_wdata;
            end
          end
        end
        if (erase_req) begin
          next_st.mode       = MODE_ERASE;
          next_st.erase_addr = '0;
        end
      end
    endcase

    // attribute word arrives one cycle after the display read
    if (st.disp_rd) begin
      next_st.attr        = ram_q;
      next_st.font_addr_r = code_addr;
      next_st.font_addr_g = code_addr;
      next_st.font_addr_b = code_addr;
      if (code_addr[8:4] == FONT_MULTI_TAG) begin
        next_st.font_addr_g = code_addr + FONT_G_OFS;
        next_st.font_addr_b = code_addr + FONT_B_OFS;
      end
    end

    // single glyphs read the same plane thrice, so OR is harmless
    if (st.font_addr_r == FONT_BLANK) begin
      next_st.glyph_bits = '0;
    end else begin
      next_st.glyph_bits = font_bits_r | font_bits_g | font_bits_b;
    end

    for (int w = 0; w < NUM_WIN; w++) begin
      hit_vec[w]   = in_area(scan_row, scan_col, st.win_rows[w], st.win_cols[w]);
      shade_vec[w] = in_shadow(scan_row, scan_col, scan_dot, scan_line,
                               st.win_rows[w], st.win_cols[w]);
    end

    // lowest rank first so the top rank is applied last
    next_st.window_hit   = 1'b0;
    next_st.shadow_hit   = 1'b0;
    next_st.window_index = '0;
    next_st.raster_color = {backdrop_intensity, st.attr[RB_BIT], st.attr[RG_BIT],
                            st.attr[RR_BIT]};
    for (int k = NUM_WIN - 1; k >= 0; k--) begin
      if (hit_vec[st.prio[k * RANK_STRIDE +: 2]]) begin
        next_st.window_hit   = 1'b1;
        next_st.shadow_hit   = 1'b0;
        next_st.window_index = st.prio[k * RANK_STRIDE +: 2];
        next_st.raster_color = st.win_rows[st.prio[k * RANK_STRIDE +: 2]][COLOR_LSB +: 4];
      end else if (shade_vec[st.prio[k * RANK_STRIDE +: 2]]) begin
        next_st.window_hit   = 1'b0;
        next_st.shadow_hit   = 1'b1;
        next_st.window_index = st.prio[k * RANK_STRIDE +: 2];
        next_st.raster_color = 4'h0;
      end
    end
    if (next_st.window_hit) begin
      next_st.raster_color = st.win_rows[next_st.window_index][COLOR_LSB +: 4];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign host_ack     = st.host_ack;
  assign host_rdata   = ram_q;
  assign erase_busy   = (st.mode == MODE_ERASE);
  assign font_addr_r  = st.font_addr_r;
  assign font_addr_g  = st.font_addr_g;
  assign font_addr_b  = st.font_addr_b;
  assign glyph_bits   = st.glyph_bits;
  assign raster_color = st.raster_color;
  assign window_hit   = st.window_hit;
  assign shadow_hit   = st.shadow_hit;
  assign window_index = st.window_index;

  // checks
  // sweep length follows the divider actually built, not the nominal twelve
  localparam int ERASE_LO = (ERASE_CELLS - 1) * RAM_CLK_DIV + 1;
  localparam int ERASE_HI = ERASE_CELLS * RAM_CLK_DIV;

  logic [12:0] erase_cycles;
  always_ff @(posedge core_clk) begin
    if (srst || st.mode != MODE_ERASE) begin
      erase_cycles <= '0;
    end else begin
      erase_cycles <= erase_cycles + 13'h0001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence erase_write_s;
    st.mode == MODE_ERASE && ram_en && ram_we;
  endsequence

  sequence erase_end_s;
    $fell(st.mode == MODE_ERASE);
  endsequence

  erase_pace_a: assert property (erase_write_s |-> tick ##1 !ram_we [*8])
    else $error("erase wrote off the ram clock");

  erase_keep_a: assert property (erase_write_s |-> ram_addr[8:5] != CTRL_ROW)
    else $error("erase touched the control row");

  erase_span_a: assert property (erase_end_s |->
      erase_cycles >= 13'(ERASE_LO) && erase_cycles <= 13'(ERASE_HI))
    else $error("erase sweep length wrong");

  erase_hold_a: assert property (st.mode == MODE_ERASE |-> ##1 !host_ack)
    else $error("host served during erase");

  blank_glyph_a: assert property (font_addr_r == FONT_BLANK |=> glyph_bits == 12'h000)
    else $error("blank address produced dots");

  multi_or_a: assert property (font_addr_r[8:4] == FONT_MULTI_TAG |->
      font_addr_b == font_addr_r + FONT_B_OFS
      ##1 glyph_bits == $past(font_bits_r | font_bits_g | font_bits_b))
    else $error("multi colour planes not combined");

  font_addr_a: assert property (st.disp_rd |=>
      font_addr_r == {$past(st.fetch_row[3]), $past(ram_q[7:0])})
    else $error("font address not formed from row and code");

  win_color_a: assert property (window_hit |->
      raster_color == st.win_rows[window_index][COLOR_LSB +: 4])
    else $error("window colour not applied");

  // enable bits as they stood when the hit was registered
  logic [NUM_WIN-1:0] win_on_seen;
  always_ff @(posedge core_clk) begin
    for (int w = 0; w < NUM_WIN; w++) begin
      win_on_seen[w] <= st.win_cols[w][ON_BIT];
    end
  end

  win_enable_a: assert property (window_hit |-> win_on_seen[window_index])
    else $error("disabled window shown");

  top_rank_a: assert property (hit_vec[st.prio[1:0]] |=>
      window_hit && window_index == $past(st.prio[1:0]))
    else $error("top ranked window not on top");

endmodule

// File: dv/osdw_host.sv
`timescale 1ns/1ps
module osdw_host (
  // clock
  input  wire logic        core_clk,
  // host port
  output logic             host_req,
  output logic             host_we,
  output logic      [3:0]  host_row,
  output logic      [4:0]  host_col,
  output logic      [15:0] host_wdata,
  input  wire logic        host_ack,
  input  wire logic [15:0] host_rdata
);
  initial begin
    host_req   = 1'b0;
    host_we    = 1'b0;
    host_row   = 4'h0;
    host_col   = 5'h00;
    host_wdata = 16'h0000;
  end

  // request held one cycle past the falling edge that samples the acknowledge high
  task automatic xfer(input logic w, input logic [3:0] r, input logic [4:0] c,
                      input logic [15:0] d, output logic [15:0] q, output logic ok);
    int n;
    n = 0;
    @(negedge core_clk);
    host_req   = 1'b1;
    host_we    = w;
    host_row   = r;
    host_col   = c;
    host_wdata = d;
    while (host_ack !== 1'b1 && n < 8000) begin
      @(negedge core_clk);
      n++;
    end
    q  = host_rdata;
    ok = (host_ack === 1'b1);
    @(negedge core_clk);
    host_req   = 1'b0;
    // released data no longer shows the last word
    host_wdata = ~d;
    host_row   = ~r;
  endtask
endmodule

// File: dv/test_osd_window_and_font_addressing.sv
`timescale 1ns/1ps
module test_osd_window_and_font_addressing;
  import osdw_pkg::*;
  localparam int DIV = RAM_CLK_DOTS;
  logic        core_clk;
  logic        srst;
  logic        host_req;
  logic        host_we;
  logic [3:0]  host_row;
  logic [4:0]  host_col;
  logic [15:0] host_wdata;
  logic        host_ack;
  logic [15:0] host_rdata;
  logic        erase_req;
  logic        erase_busy;
  logic [3:0]  scan_row;
  logic [4:0]  scan_col;
  logic [3:0]  scan_dot;
  logic [5:0]  scan_line;
  logic        bi;
  logic [8:0]  font_addr_r;
  logic [8:0]  font_addr_g;
  logic [8:0]  font_addr_b;
  logic [11:0] glyph_bits;
  logic [3:0]  raster_color;
  logic        window_hit;
  logic        shadow_hit;
  logic [1:0]  window_index;
  int          num_errors;
  int          samples_checked;
  int          cyc;

  osdw_top #(.RAM_CLK_DIV(DIV)) u_osdw_top (
    .core_clk(core_clk), .srst(srst), .host_req(host_req), .host_we(host_we),
    .host_row(host_row), .host_col(host_col), .host_wdata(host_wdata),
    .host_ack(host_ack), .host_rdata(host_rdata), .erase_req(erase_req),
    .erase_busy(erase_busy), .scan_row(scan_row), .scan_col(scan_col),
    .scan_dot(scan_dot), .scan_line(scan_line), .backdrop_intensity(bi),
    .font_addr_r(font_addr_r), .font_addr_g(font_addr_g),
    .font_addr_b(font_addr_b), .font_bits_r({font_addr_r, 3'h1}),
    .font_bits_g({font_addr_g, 3'h2}), .font_bits_b({font_addr_b, 3'h4}),
    .glyph_bits(glyph_bits), .raster_color(raster_color),
    .window_hit(window_hit), .shadow_hit(shadow_hit),
    .window_index(window_index)
  );

  osdw_host u_osdw_host (
    .core_clk(core_clk), .host_req(host_req), .host_we(host_we),
    .host_row(host_row), .host_col(host_col), .host_wdata(host_wdata),
    .host_ack(host_ack), .host_rdata(host_rdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [3:0] r, input logic [4:0] c, input logic [15:0] d);
    logic [15:0] q;
    logic        ok;
    u_osdw_host.xfer(1'b1, r, c, d, q, ok);
    chk(ok, 16'h1);
  endtask

  task automatic rdchk(input logic [3:0] r, input logic [4:0] c, input logic [15:0] e);
    logic [15:0] q;
    logic        ok;
    u_osdw_host.xfer(1'b0, r, c, 16'h0000, q, ok);
    chk(ok, 16'h1);
    chk(q, e);
  endtask

  task automatic setw(input int n, input logic [15:0] od, input logic [15:0] ev);
    wr(4'hF, 5'(5 + 2 * n), od);
    wr(4'hF, 5'(6 + 2 * n), ev);
  endtask

  task automatic t_erase();
    int n;
    n = 0;
    wr(4'h0, 5'h00, 16'hBEEF);
    wr(4'hE, 5'h1F, 16'h1357);
    wr(4'hF, 5'h05, 16'h2468);
    erase_req = 1'b1;
    @(negedge core_clk);
    erase_req = 1'b0;
    chk(erase_busy, 16'h1);
    // nothing else is sent until the sweep ends
    while (erase_busy === 1'b1 && n < 8000) begin
      @(negedge core_clk);
      n++;
    end
    chk(n >= 479 * DIV && n <= 480 * DIV - 1, 16'h1);
    rdchk(4'h0, 5'h00, 16'h0000);
    rdchk(4'hE, 5'h1F, 16'h0000);
    rdchk(4'hF, 5'h05, 16'h2468);
  endtask

  task automatic fnt(input logic [3:0] r, input logic [4:0] c, input logic [15:0] w);
    logic [8:0] a;
    logic [8:0] g;
    logic [8:0] b;
    a = {r[3], w[7:0]};
    g = (a[8:4] == 5'h1C) ? a + 9'h010 : a;
    b = (a[8:4] == 5'h1C) ? a + 9'h020 : a;
    wr(r, c, w);
    scan_row = r;
    scan_col = c;
    repeat (4 * DIV + 4) @(negedge core_clk);
    chk(font_addr_r, a);
    chk(font_addr_g, g);
    chk(font_addr_b, b);
    chk(glyph_bits, (a == 9'h000) ? 12'h000 : {a | g | b, 3'h7});
    chk(raster_color, {bi, w[13:11]});
  endtask

  // e packs hit, shadow, index (when hit) and raster colour
  task automatic win(input logic [3:0] r, input logic [4:0] c, input logic [3:0] d,
                     input logic [5:0] l, input logic [7:0] e);
    scan_row  = r;
    scan_col  = c;
    scan_dot  = d;
    scan_line = l;
    // outside a window the raster colour needs a fresh fetch of this cell
    repeat (DIV + 3) @(negedge core_clk);
    chk({window_hit, shadow_hit, window_hit ? window_index : 2'b00, raster_color}, e);
  endtask

  initial begin
    num_errors      = 0;
    samples_checked = 0;
    cyc             = 0;
    srst            = 1'b1;
    erase_req       = 1'b0;
    scan_row        = 4'h0;
    scan_col        = 5'h00;
    scan_dot        = 4'h0;
    scan_line       = 6'h00;
    bi              = 1'b1;
    repeat (5) @(negedge core_clk);
    srst = 1'b0;
    chk({erase_busy, window_hit, shadow_hit, font_addr_r}, 16'h0000);
    t_erase();
    fnt(4'h0, 5'h02, 16'h3005);
    fnt(4'h8, 5'h01, 16'h00C0);
    fnt(4'h8, 5'h03, 16'h00CF);
    fnt(4'h8, 5'h04, 16'h00D0);
    fnt(4'h8, 5'h06, 16'h00BF);
    fnt(4'h0, 5'h03, 16'h0000);
    bi = 1'b0;
    fnt(4'h9, 5'h05, 16'h18FF);
    bi = 1'b1;
    fnt(4'h9, 5'h05, 16'h18FF);
    wr(4'hF, 5'h0D, 16'h0321);
    setw(1, 16'hA244, 16'h8387);
    setw(2, 16'h5303, 16'h8505);
    win(4'h2, 5'h03, 4'h0, 6'h00, 8'h9A);
    win(4'h4, 5'h07, 4'h0, 6'h00, 8'h9A);
    win(4'h1, 5'h03, 4'h0, 6'h00, 8'h08);
    win(4'h5, 5'h07, 4'h0, 6'h00, 8'h08);
    win(4'h2, 5'h02, 4'h0, 6'h00, 8'h08);
    win(4'h3, 5'h08, 4'h1, 6'h00, 8'h40);
    win(4'h3, 5'h08, 4'h2, 6'h00, 8'h08);
    win(4'h3, 5'h05, 4'h0, 6'h00, 8'h9A);
    wr(4'hF, 5'h0D, 16'h0312);
    win(4'h3, 5'h05, 4'h0, 6'h00, 8'hA5);
    win(4'h3, 5'h04, 4'h0, 6'h00, 8'h9A);
    setw(1, 16'hA214, 16'h8387);
    win(4'h5, 5'h04, 4'h0, 6'h01, 8'h40);
    win(4'h5, 5'h04, 4'h0, 6'h02, 8'h08);
    setw(1, 16'hA214, 16'h8307);
    win(4'h5, 5'h04, 4'h0, 6'h00, 8'h08);
    setw(1, 16'hA214, 16'h0307);
    win(4'h2, 5'h03, 4'h0, 6'h00, 8'h08);
    setw(0, 16'hC000, 16'h8000);
    setw(3, 16'h3101, 16'h8101);
    win(4'h0, 5'h00, 4'h0, 6'h00, 8'h8C);
    win(4'h1, 5'h01, 4'h0, 6'h00, 8'hB3);
    print_verdict();
  end
endmodule
